// ==== design/trip_pkg.sv ====
// Shared constants and types of the trip release and indication block
package trip_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET    = 8'h00;
	localparam logic [7:0] RATING_OFFSET  = 8'h04;
	localparam logic [7:0] SDELAY_OFFSET  = 8'h08;
	localparam logic [7:0] STATUS_OFFSET  = 8'h0c;
	localparam logic [7:0] DISPLAY_OFFSET = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_ZSI_BIT          = 0;
	localparam int CTRL_GROUND_BIT       = 1;
	localparam int CTRL_NEUTRAL_BIT      = 2;
	localparam int CTRL_REMOTE_RESET_BIT = 3;
	localparam int DISPLAY_MSG_BIT       = 16;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [2:0]  CTRL_RESET   = 3'h0;
	localparam logic [15:0] PLUG_RESET   = 16'h0190;
	localparam logic [15:0] FRAME_RESET  = 16'h0320;
	localparam logic [15:0] PICKUP_RESET = 16'h0960;
	localparam logic [7:0]  DELAY_RESET  = 8'h06;

	// ------------------------------------------------------------
	// Thresholds and timing
	// ------------------------------------------------------------
	localparam logic [19:0] INRUSH_MULT      = 20'h0000b;
	localparam logic [19:0] TENTH_MULT       = 20'h0000a;
	localparam logic [19:0] DISPLAY_MIN_MULT = 20'h00014;
	localparam logic [3:0]  INRUSH_WINDOW    = 4'ha;
	localparam logic [2:0]  SELECTOR_BLANK   = 3'h7;
	localparam logic [2:0]  LAST_SELECTION   = 3'h6;
	localparam logic [2:0]  GROUND_SELECTION = 3'h3;

	// ------------------------------------------------------------
	// Display messages
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MSG_NONE,
		MSG_INRUSH,
		MSG_FIXED_INST,
		MSG_SHORT_DELAY,
		MSG_ZONE
	} message_e;

endpackage : trip_pkg

// ==== design/inrush_if.sv ====
// Carrier between the trip core and the high-inrush release
interface inrush_if;
	logic       line_tick;
	logic       above_tenth;
	logic       selector_active;
	logic       enabled;
	logic       armed;
	logic [3:0] window_count;

	modport release_end (
		input  line_tick,
		input  above_tenth,
		input  selector_active,
		output enabled,
		output armed,
		output window_count
	);

	modport core_end (
		output line_tick,
		output above_tenth,
		output selector_active,
		input  enabled,
		input  armed,
		input  window_count
	);
endinterface : inrush_if

// ==== design/inrush_release.sv ====
// High-inrush release arming window
module inrush_release (
	input wire logic     ref_clk,
	input wire logic     rst_n,
	inrush_if.release_end ir
);

	typedef struct packed {
		logic       armed;
		logic [3:0] count;
	} inrush_state_s;

	inrush_state_s st_q;
	inrush_state_s st_d;

	always_comb begin
		st_d = st_q;
		if (!ir.above_tenth) begin
			st_d.armed = 1'b1; // R4
			st_d.count = 4'h0; // R21
		end else if (ir.line_tick && st_q.armed) begin
			st_d.count = st_q.count + 4'h1; // R21
			if (st_d.count >= trip_pkg::INRUSH_WINDOW) begin
				st_d.armed = 1'b0; // R3
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '{armed: 1'b1, count: 4'h0};
		end else begin
			st_q <= st_d;
		end
	end

	// Blank selector position silences the release even while armed
	assign ir.enabled      = st_q.armed && ir.selector_active; // R6
	assign ir.armed        = st_q.armed;
	assign ir.window_count = st_q.count;

endmodule : inrush_release

// ==== design/trip_core.sv ====
// Trip release, interlock and display selection logic with AHB-Lite registers
// How it works
// (R1) Inrush release exists only in variants without adjustable instantaneous setting.
// (R2) Inrush threshold fixed at eleven times the rating plug current.
// (R3) Armed release disables after ten line cycles above 10% of frame.
// (R4) Current below 10% of frame re-arms the inrush release.
// (R5) Inrush trip: trip at once, fast-trip lamp red, inrush message.
// (R6) Seven selector positions enable inrush release; the blank one disables.
// (R7) Inactive inrush release leaves large faults to the short-time delay path.
// (R8) Fixed override above withstand rating trips without delay.
// (R9) Override trip lights fast-trip lamp and shows fixed-instantaneous message.
// (R10) Interlocking offered only with short-delay or ground-fault protection.
// (R11) Interlocked in-zone fault trips at once and restrains upstream units.
// (R12) Asserted restraint input makes the unit follow its set delays.
// (R13) Restraint never trips the unit below its own pickup.
// (R14) Installer jumpers unused interlock terminals for plain time coordination.
// (R15) Measured values in service, coded messages after a trip.
// (R16) Seven green lamps mark which quantity the display shows live.
// (R17) Step press-release advances through currents, then demand and energy.
// (R18) Ground or neutral current offered only when so configured.
// (R19) Currents shown in kiloamperes over 5% to 100% of frame.
// (R20) After a trip hold trip-free until local or remote reset.
// (R21) Ten-cycle window counted per line cycle, cleared on re-arm.
module trip_core #(
	parameter bit HAS_ADJ_INST    = 1'b0,
	parameter bit HAS_SHORT_DELAY = 1'b1,
	parameter bit HAS_GROUND      = 1'b0
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        line_cycle_tick,
	input  wire logic [15:0] phase_a_amps,
	input  wire logic [15:0] phase_b_amps,
	input  wire logic [15:0] phase_c_amps,
	input  wire logic [15:0] ground_amps,
	input  wire logic [15:0] neutral_amps,
	input  wire logic [15:0] peak_demand,
	input  wire logic [15:0] present_demand,
	input  wire logic [15:0] energy_total,
	input  wire logic        override_pickup,
	input  wire logic        restraint_in,
	input  wire logic        step_button_n,
	input  wire logic        reset_button_n,
	input  wire logic [2:0]  selector_position,
	output logic             trip_out,
	output logic             restraint_out,
	output logic             fast_trip_lamp,
	output logic [6:0]       select_lamps,
	output logic [15:0]      display_value,
	output logic [2:0]       display_message,
	output logic             display_shows_message
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic                 bus_act;
		logic                 bus_wr;
		logic [7:0]           bus_addr;
		logic [31:0]          rdata;
		logic                 zsi_en;
		logic                 ground_cfg;
		logic                 neutral_cfg;
		logic                 remote_reset;
		logic [15:0]          plug_amps;
		logic [15:0]          frame_amps;
		logic [15:0]          pickup_amps;
		logic [7:0]           delay_cycles;
		logic [7:0]           delay_count;
		logic                 step_s1;
		logic                 step_s2;
		logic                 step_prev;
		logic                 rbtn_s1;
		logic                 rbtn_s2;
		logic                 rbtn_prev;
		logic                 ovr_s1;
		logic                 ovr_s2;
		logic                 restr_s1;
		logic                 restr_s2;
		logic [2:0]           sel_s1;
		logic [2:0]           sel_s2;
		logic                 tripped;
		trip_pkg::message_e   cause;
		logic                 lamp_red;
		logic                 restraint;
		logic [2:0]           selection;
		logic [15:0]          value;
	} core_state_s;

	core_state_s st_q;
	core_state_s st_d;

	inrush_if ir ();

	inrush_release u_inrush (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ir      (ir)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] next_selection(input logic [2:0] cur, input logic gn_ok);
		logic [2:0] nxt;
		nxt = cur + 3'h1;
		if (cur >= trip_pkg::LAST_SELECTION) begin
			nxt = 3'h0;
		end else if (nxt == trip_pkg::GROUND_SELECTION && !gn_ok) begin
			nxt = trip_pkg::GROUND_SELECTION + 3'h1;
		end
		return nxt;
	endfunction : next_selection

	function automatic logic [19:0] scale(input logic [15:0] amps, input logic [19:0] mult);
		logic [19:0] wide;
		wide = {4'h0, amps};
		return 20'(wide * mult);
	endfunction : scale

	// ------------------------------------------------------------
	// Combinational view
	// ------------------------------------------------------------
	logic [15:0] max_amps;
	logic [19:0] max_x10;
	logic        inrush_present;
	logic        zsi_present;
	logic        gn_offered;
	logic        inrush_hit;
	logic        override_hit;
	logic        above_pickup;
	logic        zone_fast;
	logic        delay_done;
	logic        step_event;
	logic        local_reset;
	logic        bus_take;
	logic [15:0] shown_amps;
	logic [31:0] read_word;

	always_comb begin
		max_amps = phase_a_amps;
		if (phase_b_amps > max_amps) begin
			max_amps = phase_b_amps;
		end
		if (phase_c_amps > max_amps) begin
			max_amps = phase_c_amps;
		end
	end

	assign max_x10        = scale(max_amps, trip_pkg::TENTH_MULT);
	assign inrush_present = !HAS_ADJ_INST; // R1
	assign zsi_present    = HAS_SHORT_DELAY || HAS_GROUND; // R10
	assign gn_offered     = st_q.ground_cfg || st_q.neutral_cfg; // R18

	assign ir.line_tick       = line_cycle_tick;
	assign ir.above_tenth     = max_x10 > {4'h0, st_q.frame_amps}; // R3
	assign ir.selector_active = st_q.sel_s2 != trip_pkg::SELECTOR_BLANK; // R6

	assign inrush_hit   = inrush_present && ir.enabled
		&& {4'h0, max_amps} >= scale(st_q.plug_amps, trip_pkg::INRUSH_MULT); // R2
	assign override_hit = st_q.ovr_s2; // R8
	assign above_pickup = HAS_SHORT_DELAY && max_amps >= st_q.pickup_amps; // R13
	// Jumpered terminals read as restraint, so plain delays apply
	assign zone_fast    = zsi_present && st_q.zsi_en && above_pickup
		&& !st_q.restr_s2; // R11 R14
	assign delay_done   = above_pickup && st_q.delay_count >= st_q.delay_cycles; // R7 R12

	assign step_event  = st_q.step_s2 && !st_q.step_prev; // R17
	assign local_reset = st_q.rbtn_s2 && !st_q.rbtn_prev; // R20
	assign bus_take    = hsel && htrans[1] && hready;

	always_comb begin
		case (st_q.selection)
			3'h0: shown_amps = phase_a_amps;
			3'h1: shown_amps = phase_b_amps;
			3'h2: shown_amps = phase_c_amps;
			3'h3: shown_amps = st_q.ground_cfg ? ground_amps : neutral_amps; // R18
			default: shown_amps = 16'h0000;
		endcase
	end

	always_comb begin
		read_word = 32'h0000_0000;
		case (haddr[7:0])
			trip_pkg::CTRL_OFFSET: begin
				read_word[trip_pkg::CTRL_ZSI_BIT]     = st_q.zsi_en;
				read_word[trip_pkg::CTRL_GROUND_BIT]  = st_q.ground_cfg;
				read_word[trip_pkg::CTRL_NEUTRAL_BIT] = st_q.neutral_cfg;
			end
			trip_pkg::RATING_OFFSET: begin
				read_word = {st_q.frame_amps, st_q.plug_amps};
			end
			trip_pkg::SDELAY_OFFSET: begin
				read_word = {8'h00, st_q.delay_cycles, st_q.pickup_amps};
			end
			trip_pkg::STATUS_OFFSET: begin
				read_word = {16'h0000, ir.window_count, 1'b0, ir.selector_active,
					st_q.restr_s2, st_q.restraint, st_q.selection, ir.armed,
					st_q.cause, st_q.tripped};
			end
			trip_pkg::DISPLAY_OFFSET: begin
				read_word = {15'h0000, st_q.tripped, st_q.value};
			end
			default: read_word = 32'h0000_0000;
		endcase
		if (haddr[31:8] != 24'h00_0000) begin
			read_word = 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		st_d.remote_reset = 1'b0;

		// Pin synchronisers
		st_d.step_s1   = step_button_n;
		st_d.step_s2   = st_q.step_s1;
		st_d.step_prev = st_q.step_s2;
		st_d.rbtn_s1   = reset_button_n;
		st_d.rbtn_s2   = st_q.rbtn_s1;
		st_d.rbtn_prev = st_q.rbtn_s2;
		st_d.ovr_s1    = override_pickup;
		st_d.ovr_s2    = st_q.ovr_s1;
		st_d.restr_s1  = restraint_in;
		st_d.restr_s2  = st_q.restr_s1;
		st_d.sel_s1    = selector_position;
		st_d.sel_s2    = st_q.sel_s1;

		// Bus: address phase captured, read word staged for data phase
		st_d.bus_act = bus_take;
		if (bus_take) begin
			st_d.bus_wr   = hwrite && haddr[31:8] == 24'h00_0000;
			st_d.bus_addr = haddr[7:0];
			st_d.rdata    = hwrite ? 32'h0000_0000 : read_word;
		end
		if (st_q.bus_act && st_q.bus_wr) begin
			case (st_q.bus_addr)
				trip_pkg::CTRL_OFFSET: begin
					st_d.zsi_en       = hwdata[trip_pkg::CTRL_ZSI_BIT];
					st_d.ground_cfg   = hwdata[trip_pkg::CTRL_GROUND_BIT];
					st_d.neutral_cfg  = hwdata[trip_pkg::CTRL_NEUTRAL_BIT];
					st_d.remote_reset = hwdata[trip_pkg::CTRL_REMOTE_RESET_BIT];
				end
				trip_pkg::RATING_OFFSET: begin
					st_d.plug_amps  = hwdata[15:0];
					st_d.frame_amps = hwdata[31:16];
				end
				trip_pkg::SDELAY_OFFSET: begin
					st_d.pickup_amps  = hwdata[15:0];
					st_d.delay_cycles = hwdata[23:16];
				end
				default: begin
				end
			endcase
		end

		// Short-time delay timing, one count per line cycle
		if (!above_pickup) begin
			st_d.delay_count = 8'h00;
		end else if (line_cycle_tick && st_q.delay_count != 8'hff) begin
			st_d.delay_count = st_q.delay_count + 8'h01; // R12
		end

		// Restraint toward upstream while an in-zone fault is seen
		st_d.restraint = zsi_present && st_q.zsi_en && above_pickup; // R11

		// Trip latch: a new cause wins over a reset in the same cycle
		if (!st_q.tripped) begin
			if (override_hit) begin
				st_d.tripped  = 1'b1; // R8
				st_d.cause    = trip_pkg::MSG_FIXED_INST; // R9
				st_d.lamp_red = 1'b1; // R9
			end else if (inrush_hit) begin
				st_d.tripped  = 1'b1; // R5
				st_d.cause    = trip_pkg::MSG_INRUSH; // R5
				st_d.lamp_red = 1'b1; // R5
			end else if (zone_fast) begin
				st_d.tripped = 1'b1; // R11
				st_d.cause   = trip_pkg::MSG_ZONE;
			end else if (delay_done) begin
				st_d.tripped = 1'b1; // R7
				st_d.cause   = trip_pkg::MSG_SHORT_DELAY;
			end
		end else if ((local_reset || st_q.remote_reset)
			&& !(override_hit || inrush_hit || zone_fast || delay_done)) begin
			st_d.tripped  = 1'b0; // R20
			st_d.cause    = trip_pkg::MSG_NONE;
			st_d.lamp_red = 1'b0;
		end

		// Display selection
		if (step_event) begin
			st_d.selection = next_selection(st_q.selection, gn_offered); // R17
		end else if (st_q.selection == trip_pkg::GROUND_SELECTION && !gn_offered) begin
			st_d.selection = trip_pkg::GROUND_SELECTION + 3'h1; // R18
		end

		// Live value; currents below 5% of frame read zero, above 100% clamped to frame
		case (st_q.selection)
			3'h4: st_d.value = peak_demand; // R16
			3'h5: st_d.value = present_demand; // R16
			3'h6: st_d.value = energy_total; // R16
			default: begin
				if (scale(shown_amps, trip_pkg::DISPLAY_MIN_MULT)
					< {4'h0, st_q.frame_amps}) begin
					st_d.value = 16'h0000; // R19
				end else if (shown_amps > st_q.frame_amps) begin
					st_d.value = st_q.frame_amps; // R19
				end else begin
					st_d.value = shown_amps; // R19
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q              <= '0;
			st_q.zsi_en       <= trip_pkg::CTRL_RESET[trip_pkg::CTRL_ZSI_BIT];
			st_q.ground_cfg   <= trip_pkg::CTRL_RESET[trip_pkg::CTRL_GROUND_BIT];
			st_q.neutral_cfg  <= trip_pkg::CTRL_RESET[trip_pkg::CTRL_NEUTRAL_BIT];
			st_q.plug_amps    <= trip_pkg::PLUG_RESET;
			st_q.frame_amps   <= trip_pkg::FRAME_RESET;
			st_q.pickup_amps  <= trip_pkg::PICKUP_RESET;
			st_q.delay_cycles <= trip_pkg::DELAY_RESET;
			st_q.step_s1      <= 1'b1;
			st_q.step_s2      <= 1'b1;
			st_q.step_prev    <= 1'b1;
			st_q.rbtn_s1      <= 1'b1;
			st_q.rbtn_s2      <= 1'b1;
			st_q.rbtn_prev    <= 1'b1;
			st_q.cause        <= trip_pkg::MSG_NONE;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Zero wait states keep the slave simple; every access is OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = st_q.rdata;

	assign trip_out              = st_q.tripped; // R20
	assign restraint_out         = st_q.restraint; // R11
	assign fast_trip_lamp        = st_q.lamp_red; // R5 R9
	assign select_lamps          = 7'h01 << st_q.selection; // R16
	assign display_value         = st_q.value; // R16
	assign display_message       = st_q.cause; // R15
	assign display_shows_message = st_q.tripped; // R15

endmodule : trip_core

// ==== verification/trip_core_monitor.sv ====
// Port checker of the trip release and indication block
module trip_core_monitor (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       override_pickup,
	input wire logic       restraint_in,
	input wire logic       step_button_n,
	input wire logic       reset_button_n,
	input wire logic [2:0] selector_position,
	input wire logic       trip_out,
	input wire logic       fast_trip_lamp,
	input wire logic [6:0] select_lamps,
	input wire logic [2:0] display_message,
	input wire logic       display_shows_message
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Cycles since the reset button was held low or any bus write was issued
	// ----------------------------------------
	// Wide margin: button sync and data phase both land within it
	logic [2:0] quiet_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) quiet_q <= 3'h0;
		else if (!reset_button_n || (hsel && htrans[1] && hwrite)) quiet_q <= 3'h0;
		else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave stalled or failed");
	chk_trip_hold: assert property (trip_out && quiet_q >= 3'h5 |=> trip_out)
		else $error("trip released without reset");
	chk_override_trip: assert property ((!trip_out && override_pickup)[*3] |=>
		trip_out ##1 (fast_trip_lamp && display_message == trip_pkg::MSG_FIXED_INST))
		else $error("override did not trip");
	chk_lamp_cause: assert property (trip_out && (display_message ==
		trip_pkg::MSG_INRUSH || display_message == trip_pkg::MSG_FIXED_INST) |-> fast_trip_lamp)
		else $error("fast trip lamp dark");
	chk_blank_inert: assert property ($rose(trip_out) ##1
		display_message == trip_pkg::MSG_INRUSH |-> $past(selector_position, 3) != 3'h7 ||
		$past(selector_position, 4) != 3'h7 || $past(selector_position, 5) != 3'h7)
		else $error("inrush trip with blank selector");
	chk_zone_restraint: assert property ($rose(trip_out) ##1
		display_message == trip_pkg::MSG_ZONE |-> !$past(restraint_in, 3) ||
		!$past(restraint_in, 4) || !$past(restraint_in, 5))
		else $error("zone trip while restrained");
	chk_msg_flag: assert property (display_shows_message == trip_out)
		else $error("message flag differs from trip");
	chk_lamp_onehot: assert property ($onehot(select_lamps))
		else $error("selection lamps not one-hot");
	chk_step_moves: assert property ($rose(step_button_n) |-> ##[1:5] $changed(select_lamps))
		else $error("step release did not advance");
endmodule : trip_core_monitor

bind trip_core trip_core_monitor i_trip_core_monitor (.ref_clk, .rst_n, .hsel, .htrans,
	.hwrite, .hreadyout, .hresp, .override_pickup, .restraint_in, .step_button_n,
	.reset_button_n, .selector_position, .trip_out, .fast_trip_lamp, .select_lamps,
	.display_message, .display_shows_message);

// ==== verification/interlock_peer.sv ====
// Downstream unit on the interlock wire pair
module interlock_peer (
	input  wire logic       ref_clk,
	input  wire logic       jumpered,
	input  wire logic       fault_seen,
	input  wire logic [1:0] lag,
	output logic            restraint_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Lag models a slow peer; zero lag answers at once
	logic [3:0] line_q;
	always_ff @(posedge ref_clk) begin
		line_q <= {line_q[2:0], fault_seen};
	end
	// Jumper keeps plain time coordination when unused
	assign restraint_in = jumpered | (lag == 2'h0 ? fault_seen : line_q[lag]);
endmodule : interlock_peer

// ==== verification/trip_release_and_indication_logic_tb.sv ====
// Self-checking bench of the trip release and indication block
module trip_release_and_indication_logic_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, line_cycle_tick = 0;
	logic        override_pickup = 0, step_button_n = 1, reset_button_n = 1;
	logic        jump = 0, fault = 0, hreadyout, hresp, restraint_in, trip_out;
	logic        restraint_out, fast_trip_lamp, display_shows_message;
	logic [1:0]  htrans = 2'h0, lag = 2'h0;
	logic [2:0]  hsize = 3'h2, selector_position = 3'h0, display_message, s;
	logic [6:0]  select_lamps;
	logic [15:0] display_value, v [8], bnd [4];
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	int          mismatches = 0, cmp_count = 0, seed = 63;

	always #20 ref_clk = ~ref_clk;

	trip_core i_trip_core (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .line_cycle_tick,
		.phase_a_amps(v[0]), .phase_b_amps(v[1]), .phase_c_amps(v[2]), .ground_amps(v[3]),
		.neutral_amps(v[7]), .peak_demand(v[4]), .present_demand(v[5]),
		.energy_total(v[6]), .override_pickup, .restraint_in, .step_button_n,
		.reset_button_n, .selector_position, .trip_out, .restraint_out, .fast_trip_lamp,
		.select_lamps, .display_value, .display_message, .display_shows_message);
	interlock_peer i_interlock_peer (.ref_clk, .jumpered(jump), .fault_seen(fault), .lag,
		.restraint_in);

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic ticks(input int n);
		repeat (n) begin
			line_cycle_tick <= 1;
			cyc(1);
			line_cycle_tick <= 0;
			cyc(2);
		end
	endtask : ticks
	task automatic press(input bit rb);
		if (rb) reset_button_n <= 0;
		else step_button_n <= 0;
		cyc(4);
		reset_button_n <= 1;
		step_button_n <= 1;
		cyc(6);
	endtask : press
	function automatic logic [15:0] exp_val(input logic [15:0] a, input bit cur);
		if (cur && 32'(a) * 32'h14 < 32'(trip_pkg::FRAME_RESET)) return 16'h0000;
		if (cur && a > trip_pkg::FRAME_RESET) return trip_pkg::FRAME_RESET;
		return a;
	endfunction : exp_val

	initial begin
		#3000000;
		mismatches++;
		complete_run();
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 8; i++) v[i] = 16'h0032;
		bnd = '{16'h0027, 16'h0028, 16'h0320, 16'h0321};
		cyc(4);
		rst_n <= 1;
		chk(select_lamps, 7'h01);
		bus(trip_pkg::CTRL_OFFSET, 0, 0);
		chk(rd, 0);
		bus(trip_pkg::RATING_OFFSET, 0, 0);
		chk(rd, {trip_pkg::FRAME_RESET, trip_pkg::PLUG_RESET});
		bus(trip_pkg::SDELAY_OFFSET, 0, 0);
		chk(rd, {8'h00, trip_pkg::DELAY_RESET, trip_pkg::PICKUP_RESET});
		bus(trip_pkg::SDELAY_OFFSET, 1, 32'h0004_0960);
		bus(trip_pkg::SDELAY_OFFSET, 0, 0);
		chk(rd, 32'h0004_0960);
		bus(8'h20, 1, 32'hffff_ffff);
		bus(8'h20, 0, 0);
		chk(rd, 0);
		// Selection walk with neither, ground only, then neutral only configured
		for (int g = 0; g < 3; g++) begin
			bus(trip_pkg::CTRL_OFFSET, 1, 32'(g * 2));
			for (int i = 0; i < 8; i++) v[i] <= 16'(40 + {$random(seed)} % 761);
			s = 0;
			repeat (g ? 7 : 6) begin
				s = (s == 6) ? 3'h0 : (s == 2 && g == 0) ? 3'h4 : s + 3'h1;
				press(0);
				chk(select_lamps, 7'h01 << s);
				chk(display_value, exp_val(v[(s == 3 && g == 2) ? 7 : s], s < 4));
			end
		end
		for (int i = 0; i < 4; i++) begin
			v[0] <= bnd[i];
			cyc(3);
			chk(display_value, exp_val(bnd[i], 1));
		end
		// Arming window at the ten percent boundary
		for (int i = 0; i < 3; i++) v[i] <= 16'h0050;
		cyc(3);
		v[0] <= 16'h0051;
		ticks(9);
		bus(trip_pkg::STATUS_OFFSET, 0, 0);
		chk(rd[15:12], 9);
		chk(rd[4], 1);
		ticks(1);
		bus(trip_pkg::STATUS_OFFSET, 0, 0);
		chk(rd[4], 0);
		v[0] <= 16'h1130;
		cyc(5);
		chk(trip_out, 0);
		v[0] <= 16'h0050;
		cyc(3);
		bus(trip_pkg::STATUS_OFFSET, 0, 0);
		chk(rd[15:12], 0);
		chk(rd[4], 1);
		// Every selector position
		for (int p = 0; p < 8; p++) begin
			selector_position <= 3'(p);
			cyc(5);
			v[0] <= 16'h112f;
			cyc(3);
			chk(trip_out, 0);
			v[0] <= 16'h1130;
			cyc(3);
			chk(trip_out, p != 7);
			chk(fast_trip_lamp, p != 7);
			if (p != 7) chk(display_message, trip_pkg::MSG_INRUSH);
			else ticks(4);
			if (p == 7) chk(display_message, trip_pkg::MSG_SHORT_DELAY);
			cyc(20);
			chk(trip_out, 1);
			v[0] <= 16'h0050;
			if (p[0]) bus(trip_pkg::CTRL_OFFSET, 1, 32'h8);
			else press(1);
			cyc(2);
			chk(trip_out, 0);
		end
		override_pickup <= 1;
		cyc(4);
		chk(display_message, trip_pkg::MSG_FIXED_INST);
		override_pickup <= 0;
		press(1);
		// Interlock: below pickup, restrained, then free
		bus(trip_pkg::CTRL_OFFSET, 1, 32'h1);
		lag <= 2'($random(seed));
		jump <= 1;
		v[0] <= 16'h095f;
		ticks(6);
		chk(trip_out, 0);
		chk(restraint_out, 0);
		jump <= 0;
		fault <= 1;
		cyc(8);
		v[0] <= 16'h0960;
		cyc(3);
		chk(trip_out, 0);
		chk(restraint_out, 1);
		ticks(4);
		chk(display_message, trip_pkg::MSG_SHORT_DELAY);
		v[0] <= 16'h0050;
		fault <= 0;
		bus(trip_pkg::CTRL_OFFSET, 1, 32'h9);
		cyc(8);
		v[0] <= 16'h0960;
		cyc(3);
		chk(trip_out, 1);
		chk(display_message, trip_pkg::MSG_ZONE);
		complete_run();
	end
endmodule : trip_release_and_indication_logic_tb
